/* File: rtl/sq_create_pkg.sv */
/*
  Constants, field layouts, status codes and carrier structs shared by
  the submission queue creation decoder and its descriptor store.
  Assumes a single controller clock and an admin dispatcher upstream.
*/
package sq_create_pkg;

  // ==========================================================
  // widths and table sizes
  localparam int QNUM_W = 16;
  localparam int QIDX_W = 4;
  localparam int NUM_SQ = 16;
  localparam int NUM_CQ = 16;
  localparam int IRQ_W  = 2;
  localparam logic [QNUM_W-1:0] SQ_LIMIT = 16'h0010;
  localparam logic [QNUM_W-1:0] CQ_LIMIT = 16'h0010;
  localparam logic [QNUM_W-1:0] ADMIN_QNUM = 16'h0000;

  // ==========================================================
  // command word field positions
  localparam int SIZE_LSB   = 16;
  localparam int QNUM_LSB   = 0;
  localparam int CQ_LSB     = 16;
  localparam int PRIO_LSB   = 1;
  localparam int CONTIG_BIT = 0;
  // only target queue, priority and contiguity bits of word eleven
  localparam logic [31:0] WORD11_USED = 32'hFFFF_0007;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL        = 8'h00;
  localparam logic [7:0] OFF_MAX_ENTRIES = 8'h04;
  localparam logic [7:0] OFF_SQ_GRANTED  = 8'h08;
  localparam logic [7:0] OFF_CQ_EXISTS   = 8'h0C;
  localparam logic [7:0] OFF_INT_STATUS  = 8'h10;
  localparam logic [7:0] OFF_INT_MASK    = 8'h14;
  localparam logic [7:0] OFF_SQ_IN_USE   = 8'h18;
  localparam logic [7:0] OFF_LOOKUP_SEL  = 8'h1C;
  localparam logic [7:0] OFF_LOOKUP_LO   = 8'h20;
  localparam logic [7:0] OFF_LOOKUP_HI   = 8'h24;
  localparam logic [7:0] OFF_LOOKUP_INFO = 8'h28;

  // control register fields and reset values
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_ARB_LSB = 1;
  localparam logic [1:0]  ARB_WRR_URGENT    = 2'h1;
  localparam logic [1:0]  ARB_RESET         = 2'h0;
  localparam logic [15:0] MAX_ENTRIES_RESET = 16'h003F;
  localparam logic [15:0] GRANTED_RESET     = 16'h0000;
  localparam int IRQ_CREATED  = 0;
  localparam int IRQ_REJECTED = 1;

  // ==========================================================
  // completion status
  localparam logic [2:0] SCT_GENERIC  = 3'h0;
  localparam logic [2:0] SCT_SPECIFIC = 3'h1;
  localparam logic [7:0] SC_SUCCESS     = 8'h00;
  localparam logic [7:0] SC_CQ_INVALID  = 8'h00;
  localparam logic [7:0] SC_QID_INVALID = 8'h01;
  localparam logic [7:0] SC_SIZE_EXCEED = 8'h02;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    PRIO_URGENT = 2'h0,
    PRIO_HIGH   = 2'h1,
    PRIO_MEDIUM = 2'h2,
    PRIO_LOW    = 2'h3
  } prio_class_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_POST  = 2'b11
  } dec_state_e;

  typedef struct packed {
    logic [15:0] cid;
    logic [63:0] first_page_pointer;
    logic [31:0] word_ten;
    logic [31:0] word_eleven;
  } admin_cmd_s;

  typedef struct packed {
    logic [15:0] cid;
    logic [2:0]  sct;
    logic [7:0]  sc;
  } completion_s;

  typedef struct packed {
    logic [63:0]       base;
    logic              is_page_list;
    logic [15:0]       queue_entry_count;
    logic [QNUM_W-1:0] target_completion_queue_number;
    prio_class_e       priority_class;
    logic              prio_applied;
  } sq_desc_s;

  typedef struct packed {
    sq_desc_s          desc;
    logic [QNUM_W-1:0] queue_number;
  } sq_create_s;

  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } avmm_req_s;

  // ==========================================================
  // a queue number within a table and set in its occupancy map
  function automatic logic in_map(input logic [QNUM_W-1:0] num,
                                  input logic [QNUM_W-1:0] limit,
                                  input logic [NUM_SQ-1:0] map);
    return (num < limit) && map[num[QIDX_W-1:0]];
  endfunction

endpackage

/* File: rtl/sq_desc_ram.sv */
/*
  Descriptor store for created submission queues, one word per queue.
  Assumes one write port and one read port; read data are registered.
*/
`timescale 1ns/1ps
module sq_desc_ram
  import sq_create_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // write port
  input  wire logic              we,
  input  wire logic [QIDX_W-1:0] waddr,
  input  wire sq_desc_s          wdata,
  // read port
  input  wire logic [QIDX_W-1:0] raddr,
  output sq_desc_s               rdata
);

  // ==========================================================
  // state
  typedef struct packed {
    sq_desc_s [NUM_SQ-1:0] mem;
    sq_desc_s              rdata;
  } ram_state_s;

  ram_state_s st_q;
  ram_state_s st_d;

  always_comb begin
    st_d = st_q;
    if (we) begin
      st_d.mem[waddr] = wdata;
    end
    // old contents on a same-address write; lookup is not time critical
    st_d.rdata = st_q.mem[raddr];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;

endmodule // sq_desc_ram

/* File: rtl/sq_create_decode.sv */
/*
  Decoder for the admin command that creates an I/O submission queue:
  field extraction, validation, descriptor storage, completion posting,
  Avalon-MM register slave and a level interrupt.
  Assumes an admin dispatcher that hands over only this command and a
  completion writer that accepts entries on a valid/ready handshake.
*/
`timescale 1ns/1ps
module sq_create_decode
  import sq_create_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // register bus
  input  wire avmm_req_s         avs_req,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // admin command in
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire admin_cmd_s        cmd,
  // completion out
  output logic                   cpl_valid,
  input  wire logic              cpl_ready,
  output completion_s            cpl,
  // created queue out
  output logic                   created_valid,
  output sq_create_s             created,
  output logic [NUM_SQ-1:0]      doorbell_enable,
  // interrupt
  output logic                   irq
);

  // ==========================================================
  // state
  typedef struct packed {
    dec_state_e        fsm;
    admin_cmd_s        cmd;
    completion_s       cpl;
    sq_create_s        created;
    logic              created_valid;
    logic [NUM_SQ-1:0] in_use;
    logic              enable;
    logic [1:0]        arb;
    logic [15:0]       max_entries;
    logic [15:0]       granted;
    logic [NUM_CQ-1:0] cq_exists;
    logic [IRQ_W-1:0]  int_status;
    logic [IRQ_W-1:0]  int_mask;
    logic [QIDX_W-1:0] lookup_sel;
    logic              rd_ack;
    logic [31:0]       rdata;
  } dec_state_s;

  dec_state_s st_q;
  dec_state_s st_d;

  sq_desc_s   lookup_desc;
  sq_desc_s   new_desc;
  logic       mem_we;

  // ==========================================================
  // field extraction
  logic [31:0]       w11;
  logic [QNUM_W-1:0] qnum;
  logic [QNUM_W-1:0] cqnum;
  logic [15:0]       entries;
  logic              qid_bad;
  logic              cq_bad;
  logic              size_bad;
  logic              prio_on;

  always_comb begin
    w11      = st_q.cmd.word_eleven & WORD11_USED;
    qnum     = st_q.cmd.word_ten[QNUM_LSB +: QNUM_W];
    cqnum    = w11[CQ_LSB +: QNUM_W];
    entries  = st_q.cmd.word_ten[SIZE_LSB +: 16];
    prio_on  = (st_q.arb == ARB_WRR_URGENT);
    // number zero is the admin queue, never made here
    qid_bad  = (qnum == ADMIN_QNUM) || (qnum > st_q.granted)
               || in_map(qnum, SQ_LIMIT, st_q.in_use)
               || !(qnum < SQ_LIMIT);
    cq_bad   = (cqnum == ADMIN_QNUM)
               || !in_map(cqnum, CQ_LIMIT, st_q.cq_exists);
    // both sides zero-based, so a plain compare of the fields
    size_bad = entries > st_q.max_entries;

    new_desc = '0;
    new_desc.base         = st_q.cmd.first_page_pointer;
    new_desc.is_page_list = !w11[CONTIG_BIT];
    new_desc.queue_entry_count              = entries;
    new_desc.target_completion_queue_number = cqnum;
    new_desc.prio_applied = prio_on;
    // ignored field shows as urgent with the applied flag low
    new_desc.priority_class = prio_on ?
      prio_class_e'(w11[PRIO_LSB +: 2]) : PRIO_URGENT;
  end

  // ==========================================================
  // next state
  logic [31:0] rd_mux;
  logic        rd_take;
  logic [IRQ_W-1:0] irq_set;

  always_comb begin
    st_d    = st_q;
    mem_we  = 1'b0;
    irq_set = '0;
    st_d.created_valid = 1'b0;

    case (st_q.fsm)
      ST_IDLE: begin
        if (cmd_valid && st_q.enable) begin
          st_d.cmd = cmd;
          st_d.fsm = ST_CHECK;
        end
      end
      ST_CHECK: begin
        st_d.cpl.cid = st_q.cmd.cid;
        st_d.cpl.sct = SCT_SPECIFIC;
        if (qid_bad) begin
          st_d.cpl.sc = SC_QID_INVALID;
        end else if (cq_bad) begin
          st_d.cpl.sc = SC_CQ_INVALID;
        end else if (size_bad) begin
          st_d.cpl.sc = SC_SIZE_EXCEED;
        end else begin
          st_d.cpl.sct = SCT_GENERIC;
          st_d.cpl.sc  = SC_SUCCESS;
          mem_we = 1'b1;
          st_d.in_use[qnum[QIDX_W-1:0]] = 1'b1;
          st_d.created.desc         = new_desc;
          st_d.created.queue_number = qnum;
          st_d.created_valid        = 1'b1;
        end
        irq_set[IRQ_CREATED]  = !(qid_bad || cq_bad || size_bad);
        irq_set[IRQ_REJECTED] = qid_bad || cq_bad || size_bad;
        st_d.fsm = ST_POST;
      end
      ST_POST: begin
        if (cpl_ready) begin
          st_d.fsm = ST_IDLE;
        end
      end
      default: begin
        st_d.fsm = ST_IDLE;
      end
    endcase

    // register reads: one wait cycle, then registered data
    rd_take = avs_req.read && !st_q.rd_ack;
    st_d.rd_ack = rd_take;
    rd_mux = '0;
    case (avs_req.address)
      OFF_CTRL: begin
        rd_mux[CTRL_EN_BIT] = st_q.enable;
        rd_mux[CTRL_ARB_LSB +: 2] = st_q.arb;
      end
      OFF_MAX_ENTRIES: rd_mux[15:0] = st_q.max_entries;
      OFF_SQ_GRANTED:  rd_mux[15:0] = st_q.granted;
      OFF_CQ_EXISTS:   rd_mux[NUM_CQ-1:0] = st_q.cq_exists;
      OFF_INT_STATUS:  rd_mux[IRQ_W-1:0] = st_q.int_status;
      OFF_INT_MASK:    rd_mux[IRQ_W-1:0] = st_q.int_mask;
      OFF_SQ_IN_USE:   rd_mux[NUM_SQ-1:0] = st_q.in_use;
      OFF_LOOKUP_SEL:  rd_mux[QIDX_W-1:0] = st_q.lookup_sel;
      OFF_LOOKUP_LO:   rd_mux = lookup_desc.base[31:0];
      OFF_LOOKUP_HI:   rd_mux = lookup_desc.base[63:32];
      OFF_LOOKUP_INFO: begin
        rd_mux = {lookup_desc.queue_entry_count,
                  lookup_desc.target_completion_queue_number[11:0],
                  lookup_desc.prio_applied,
                  lookup_desc.is_page_list,
                  lookup_desc.priority_class};
      end
      default: rd_mux = '0;
    endcase
    if (rd_take) begin
      st_d.rdata = rd_mux;
      if (avs_req.address == OFF_INT_STATUS) begin
        st_d.int_status = '0;
      end
    end

    // register writes: taken at once, unmapped offsets dropped
    if (avs_req.write) begin
      case (avs_req.address)
        OFF_CTRL: begin
          st_d.enable = avs_req.writedata[CTRL_EN_BIT];
          st_d.arb    = avs_req.writedata[CTRL_ARB_LSB +: 2];
        end
        OFF_MAX_ENTRIES: st_d.max_entries = avs_req.writedata[15:0];
        OFF_SQ_GRANTED:  st_d.granted = avs_req.writedata[15:0];
        OFF_CQ_EXISTS:   st_d.cq_exists = avs_req.writedata[NUM_CQ-1:0];
        OFF_INT_MASK:    st_d.int_mask = avs_req.writedata[IRQ_W-1:0];
        OFF_LOOKUP_SEL:  st_d.lookup_sel = avs_req.writedata[QIDX_W-1:0];
        default: begin
        end
      endcase
    end

    // a new event beats a read clear in the same cycle
    st_d.int_status = st_d.int_status | irq_set;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q             <= '0;
      st_q.fsm         <= ST_IDLE;
      st_q.arb         <= ARB_RESET;
      st_q.max_entries <= MAX_ENTRIES_RESET;
      st_q.granted     <= GRANTED_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // descriptor store
  sq_desc_ram u_desc_ram (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .we       (mem_we),
    .waddr    (qnum[QIDX_W-1:0]),
    .wdata    (new_desc),
    .raddr    (st_q.lookup_sel),
    .rdata    (lookup_desc)
  );

  // ==========================================================
  // outputs
  assign cmd_ready       = (st_q.fsm == ST_IDLE) && st_q.enable;
  assign cpl_valid       = (st_q.fsm == ST_POST);
  assign cpl             = st_q.cpl;
  assign created_valid   = st_q.created_valid;
  assign created         = st_q.created;
  assign doorbell_enable = st_q.in_use;
  assign irq             = |(st_q.int_status & st_q.int_mask);
  assign avs_readdata    = st_q.rdata;
  assign avs_waitrequest = avs_req.read && !st_q.rd_ack;

endmodule // sq_create_decode

/* File: test/sq_create_decode_chk.sv */
/*
  Port assertions for the submission queue creation decoder.
  Assumes it is bound onto sq_create_decode, one clock domain.
*/
`timescale 1ns/1ps
module sq_create_decode_chk
  import sq_create_pkg::*;
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              rst_n,
  // command and completion
  input wire logic              cmd_valid,
  input wire logic              cmd_ready,
  input wire admin_cmd_s        cmd,
  input wire logic              cpl_valid,
  input wire logic              cpl_ready,
  input wire completion_s       cpl,
  // created queue
  input wire logic              created_valid,
  input wire sq_create_s        created,
  input wire logic [NUM_SQ-1:0] doorbell_enable
);
  // ==========================================
  // sequences
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_made;
    s_take ##2 created_valid;
  endsequence

  // ==========================================
  // assertions
  a_cpl_after_take: assert property (
    s_take |=> !cmd_ready ##1 cpl_valid)
    else $error("completion not posted two cycles after take");
  a_cpl_hold: assert property (
    cpl_valid && !cpl_ready |=> cpl_valid && $stable(cpl))
    else $error("completion dropped or changed while stalled");
  a_base_kind: assert property (
    s_made |-> created.desc.base == $past(cmd.first_page_pointer, 2)
    && created.desc.is_page_list == !$past(cmd.word_eleven[0], 2))
    else $error("base or page list flag wrong");
  a_size_ids: assert property (
    s_made |-> created.desc.queue_entry_count == $past(cmd.word_ten[31:16], 2)
    && created.queue_number == $past(cmd.word_ten[15:0], 2)
    && created.desc.target_completion_queue_number
       == $past(cmd.word_eleven[31:16], 2))
    else $error("size or queue numbers wrong");
  a_prio_code: assert property (
    s_made ##0 created.desc.prio_applied
    |-> created.desc.priority_class == $past(cmd.word_eleven[2:1], 2))
    else $error("priority class wrong");
  a_prio_off: assert property (
    created_valid && !created.desc.prio_applied
    |-> created.desc.priority_class == PRIO_URGENT)
    else $error("priority kept while not applied");
  a_ok_status: assert property (
    created_valid |-> cpl_valid && cpl.sct == SCT_GENERIC
    && cpl.sc == SC_SUCCESS)
    else $error("creation without success status");
  a_door_sel: assert property (
    created_valid |-> doorbell_enable[created.queue_number[QIDX_W-1:0]]
    && created.queue_number != ADMIN_QNUM)
    else $error("doorbell not enabled or admin queue made");
  a_admin_cq: assert property (
    created_valid
    |-> created.desc.target_completion_queue_number != ADMIN_QNUM)
    else $error("admin completion queue accepted as target");
  a_one_pulse: assert property (
    created_valid |=> !created_valid)
    else $error("created pulse longer than one cycle");
endmodule // sq_create_decode_chk

bind sq_create_decode sq_create_decode_chk u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd(cmd), .cpl_valid(cpl_valid),
  .cpl_ready(cpl_ready), .cpl(cpl), .created_valid(created_valid),
  .created(created), .doorbell_enable(doorbell_enable));

/* File: test/host_model.sv */
/*
  Host side model: offers one admin command per go pulse and
  accepts completions, promptly or with stalls.
  Assumes go is raised only while no command is outstanding.
*/
`timescale 1ns/1ps
module host_model
  import sq_create_pkg::*;
(
  // clock and bench control
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic       slow,
  input  wire admin_cmd_s cmd_in,
  // decoder side
  output logic            cmd_valid,
  input  wire logic       cmd_ready,
  output admin_cmd_s      cmd,
  output logic            cpl_ready
);
  logic [1:0] stall_q;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    cpl_ready = 1'b0;
    stall_q = 2'h0;
  end
  always @(posedge core_clk) begin
    stall_q <= stall_q + 2'h1;
    cpl_ready <= !slow || stall_q == 2'h3;
    if (cmd_valid && cmd_ready) begin
      cmd_valid <= 1'b0;
      // released lines must not look like a live command
      cmd <= ~cmd;
    end else if (go && !cmd_valid) begin
      cmd_valid <= 1'b1;
      // page lists are never moved or deleted here
      cmd <= cmd_in;
    end
  end
endmodule // host_model

/* File: test/testbench.sv */
/*
  Self-checking bench for sq_create_decode with a reference model.
  Assumes the host_model partner and the bound checker.
*/
`timescale 1ns/1ps
module testbench;
  import sq_create_pkg::*;
  logic        core_clk, rst_n, go, slow, cmd_valid, cmd_ready;
  logic        cpl_valid, cpl_ready, created_valid, irq, avs_waitrequest;
  logic [31:0] avs_readdata, rd, m;
  logic [15:0] doorbell_enable;
  avmm_req_s   avs_req;
  admin_cmd_s  cmd, cmd_in;
  completion_s cpl;
  sq_create_s  created, got_made;
  logic [63:0] last_ptr;
  logic [31:0] last_info;
  int error_cnt, tests_run, seed, granted, arb, saw, ist, cqex;
  int used[16];

  sq_create_decode dut (.core_clk(core_clk), .rst_n(rst_n),
    .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .cpl_valid(cpl_valid),
    .cpl_ready(cpl_ready), .cpl(cpl), .created_valid(created_valid),
    .created(created), .doorbell_enable(doorbell_enable), .irq(irq));
  host_model host (.core_clk(core_clk), .go(go), .slow(slow),
    .cmd_in(cmd_in), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .cpl_ready(cpl_ready));

  // ==========================================
  // shared tasks
  task automatic check(string what, logic [127:0] exp, logic [127:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_req <= '{a, !wr, wr, wd};
    // values read at the edge are those that stood before it
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest && n < 50);
    if (avs_waitrequest) error_cnt++;
    rd = avs_readdata;
    avs_req <= '0;
  endtask
  task automatic run_cmd(int qn, int cq, int sz, logic [2:0] lo);
    admin_cmd_s c;
    logic [31:0] r;
    int sc, n;
    r = $random(seed);
    c.cid = r[31:16];
    c.first_page_pointer = {$random(seed), r[31:12], 12'h000};
    c.word_ten = {sz[15:0], qn[15:0]};
    c.word_eleven = {cq[15:0], r[15:3], lo};
    if (qn == 0 || qn > granted || qn >= 16 || used[qn[3:0]]) sc = 1;
    else if (cq == 0 || cq >= 16 || !cqex[cq[3:0]]) sc = 0;
    else if (sz > 63) sc = 2;
    else sc = 8;
    @(posedge core_clk);
    go <= 1'b1;
    cmd_in <= c;
    @(posedge core_clk);
    go <= 1'b0;
    saw = 0;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
      if (created_valid) saw = 1;
      if (created_valid) got_made = created;
    end while (!(cpl_valid && cpl_ready) && n < 100);
    if (!(cpl_valid && cpl_ready)) error_cnt++;
    check("cpl", {c.cid, sc == 8 ? SCT_GENERIC : SCT_SPECIFIC,
      sc == 8 ? SC_SUCCESS : sc[7:0]}, cpl);
    check("made", sc == 8, saw);
    ist = ist | (sc == 8 ? 1 : 2);
    if (sc == 8) begin
      used[qn] = 1;
      last_ptr = c.first_page_pointer;
      last_info = {sz[15:0], cq[11:0], arb == 1, !lo[0],
        arb == 1 ? lo[2:1] : 2'h0};
      check("desc", {c.first_page_pointer, !lo[0], sz[15:0], cq[15:0],
        arb == 1 ? lo[2:1] : 2'h0, arb == 1, qn[15:0]},
        got_made);
    end
    for (int i = 0; i < 16; i++) m[i] = used[i];
    check("doorbells", m[15:0], doorbell_enable);
  endtask

  // ==========================================
  // clock, reset, watchdog
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #(100 * 6000);
    error_cnt++;
    finish_test();
  end

  // ==========================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    slow = 1'b0;
    avs_req = '0;
    cmd_in = '0;
    seed = 29;
    arb = 1;
    granted = 8;
    cqex = 6;
    ist = 0;
    m = '0;
    foreach (used[i]) used[i] = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    // reset values, then unmapped and misaligned reads give zero
    bus(0, OFF_CTRL, 0);
    check("ctrl", 0, rd);
    bus(0, OFF_MAX_ENTRIES, 0);
    check("max", 32'h0000_003F, rd);
    bus(0, 8'h30, 0);
    check("unmapped", 0, rd);
    bus(0, 8'h02, 0);
    check("misaligned", 0, rd);
    bus(1, OFF_CTRL, 32'h0000_0003);
    bus(1, OFF_SQ_GRANTED, 32'h0000_0008);
    bus(1, OFF_CQ_EXISTS, 32'h0000_0006);
    bus(1, OFF_INT_MASK, 32'h0000_0003);
    bus(0, OFF_SQ_GRANTED, 0);
    check("granted", granted, rd);
    bus(0, OFF_CQ_EXISTS, 0);
    check("cq exists", cqex, rd);
    bus(0, OFF_INT_MASK, 0);
    check("mask", 3, rd);
    $display("test registers done");
    // refusals: two for queue id, two for completion queue, one for size, then all three at once
    run_cmd(0, 1, 4, 3'h1);
    run_cmd(9, 1, 4, 3'h1);
    run_cmd(2, 0, 4, 3'h1);
    run_cmd(2, 3, 4, 3'h1);
    run_cmd(2, 1, 64, 3'h1);
    run_cmd(0, 0, 64, 3'h0);
    $display("test refusals done");
    // every priority code, both buffer kinds, stalled completions
    for (int i = 0; i < 4; i++) begin
      slow <= i[0];
      run_cmd(i + 1, 1 + i[0], $random(seed) & 63, {i[1:0], i[0]});
    end
    run_cmd(1, 2, 0, 3'h0);
    $display("test priorities done");
    bus(1, OFF_CTRL, 32'h0000_0001);
    arb = 0;
    run_cmd(8, 2, 63, 3'h7);
    $display("test arbitration off done");
    check("irq", 1, irq);
    bus(0, OFF_INT_STATUS, 0);
    check("status", ist, rd);
    check("irq clear", 0, irq);
    ist = 0;
    bus(1, OFF_INT_MASK, 0);
    run_cmd(8, 2, 5, 3'h0);
    check("irq masked", 0, irq);
    bus(0, OFF_INT_STATUS, 0);
    check("status masked", ist, rd);
    bus(1, OFF_SQ_IN_USE, 32'h0000_FFFF);
    bus(0, OFF_SQ_IN_USE, 0);
    check("in use", m, rd);
    $display("test interrupts done");
    bus(1, OFF_LOOKUP_SEL, 32'h0000_0008);
    bus(0, OFF_LOOKUP_SEL, 0);
    check("lookup sel", 8, rd);
    bus(0, OFF_LOOKUP_LO, 0);
    check("lookup lo", last_ptr[31:0], rd);
    bus(0, OFF_LOOKUP_HI, 0);
    check("lookup hi", last_ptr[63:32], rd);
    bus(0, OFF_LOOKUP_INFO, 0);
    check("lookup info", last_info, rd);
    $display("test lookup done");
    finish_test();
  end
endmodule // testbench
